/* File: rtl/cpx_map.svh */
// Overview of operation
// - Null with come-again and interrupts-allowed: service interrupts
// - Trace pending, null not finished, interrupts-allowed: service interrupts
// - Null-response interrupts use ten-word frame, then resume
// - Save not-ready word: interrupts, four-word frame, retry
// - Length not multiple of four is format error
// - Save bad length: abort mask, then format error
// - Restore bad length: write, read, abort, error
// - Format error uses four-word frame, vector 14
// - Bus error on first access means absent coprocessor
// - Later bus errors take bus error exception, except on the abort write
// - Odd prefetch address while idle raises address error
// - Function code all zeros or ones: protocol violation
// - Reserved function codes: protocol violation
// - Trace pending: keep reading until null finished
// - Emulator exception: four-word frame, vector 11
`ifndef CPX_MAP_SVH
`define CPX_MAP_SVH
`define CPX_FC_HI 13
`define CPX_FC_LO 8
`define CPX_CA_BIT 15
`define CPX_IA_BIT 8
`define CPX_PF_BIT 1
`define CPX_FC_NULL 6'h08
`define CPX_FC_NULL_MASK 6'h3e
`define CPX_FC_ONES 6'h3f
`define CPX_FC_ZERO 6'h00
`define CPX_FC_RES0 6'h0b
`define CPX_FC_RES1 6'h1f
`define CPX_NOTREADY 16'h0100
`define CPX_LEN_LO_MASK 8'h03
`define CPX_VEC_FMT 8'h0e
`define CPX_VEC_EMU 8'h0b
`define CPX_VEC_BUS 8'h02
`define CPX_VEC_ADR 8'h03
`define CPX_VEC_PROT 8'h0d
`define CPX_VEC_INT 8'h00
`define CPX_FRAME_PRE 4'h4
`define CPX_FRAME_MID 4'ha
`endif

/* File: rtl/cpx_pkg.sv */
package cpx_pkg;
    typedef enum logic [8:0] {
        CPX_IDLE = 9'h001,
        CPX_RESP = 9'h002,
        CPX_SAVE = 9'h004,
        CPX_RWR = 9'h008,
        CPX_RRD = 9'h010,
        CPX_ABORT = 9'h020,
        CPX_INTR = 9'h040,
        CPX_EXC = 9'h080,
        CPX_DONE = 9'h100
    } cpx_state_e;
    typedef enum logic [1:0] {
        CPX_OP_GEN = 2'h0,
        CPX_OP_COND = 2'h1,
        CPX_OP_SAVE = 2'h2,
        CPX_OP_RESTORE = 2'h3
    } cpx_op_e;
endpackage

/* File: rtl/cpx_exc_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cpx_map.svh"
// Coprocessor exception sequencer of the main processor. Each access step
// issues a one-cycle request and waits for busAck or busErr.
module cpx_exc_ctrl
    import cpx_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic start,
    input wire logic [1:0] opKind,
    input wire logic tracePending,
    input wire logic intPending,
    input wire logic [15:0] memFormatWord,
    input wire logic prefetchReq,
    input wire logic [31:0] prefetchAddr,
    input wire logic busAck,
    input wire logic busErr,
    input wire logic [15:0] busRdata,
    input wire logic excReturn,
    output logic readResponse,
    output logic readSave,
    output logic writeRestore,
    output logic readRestore,
    output logic writeAbort,
    output logic [15:0] busWdata,
    output logic excTake,
    output logic [7:0] excVector,
    output logic [3:0] excFrameWords,
    output logic intService,
    output logic busy,
    output logic instrDone
);
    cpx_state_e state, next_state;
    logic [1:0] op;
    logic firstAccess;
    logic pending;
    logic [7:0] pendVec;
    logic [3:0] pendFrame;
    logic [15:0] restoreWord;
    logic intFromSave;

    wire logic stepReq = readResponse | readSave | writeRestore |
        readRestore | writeAbort;
    wire logic waiting = pending;
    wire logic [5:0] fc = busRdata[`CPX_FC_HI:`CPX_FC_LO];
    wire logic caFlag = busRdata[`CPX_CA_BIT];
    wire logic iaFlag = busRdata[`CPX_IA_BIT];
    wire logic pfFlag = busRdata[`CPX_PF_BIT];
    // Interrupts-allowed flag sits in the low bit of the null code
    wire logic isNull = (fc & `CPX_FC_NULL_MASK) == `CPX_FC_NULL;
    wire logic protErr = fc == `CPX_FC_ZERO || fc == `CPX_FC_ONES ||
        fc == `CPX_FC_RES0 || fc == `CPX_FC_RES1 ||
        (fc[3:2] == 2'h2 && fc[5:4] != 2'h0) ||
        (fc[5:2] == 4'h6);
    wire logic nullInt = isNull && iaFlag &&
        (caFlag || (tracePending && op == CPX_OP_GEN && !pfFlag));
    wire logic nullDone = isNull && !caFlag &&
        (!tracePending || op != CPX_OP_GEN || pfFlag);
    wire logic saveLenBad = (busRdata[7:0] & `CPX_LEN_LO_MASK) != 8'h00;
    wire logic restLenBad = (restoreWord[7:0] & `CPX_LEN_LO_MASK) != 8'h00;
    wire logic saveNotReady = busRdata == `CPX_NOTREADY;
    wire logic addrErr = prefetchReq && prefetchAddr[0];
    // Restore word still loading when the write leaves idle
    wire logic [15:0] restoreSrc = (state == CPX_IDLE) ? memFormatWord :
        restoreWord;

    always_comb begin
        next_state = state;
        unique case (state)
            CPX_IDLE: if (addrErr) next_state = CPX_EXC;
                else if (start) next_state = (opKind == CPX_OP_SAVE) ?
                    CPX_SAVE : (opKind == CPX_OP_RESTORE) ? CPX_RWR : CPX_RESP;
            CPX_RESP: if (waiting && busErr) next_state = CPX_EXC;
                else if (waiting && busAck) begin
                    if (protErr) next_state = CPX_ABORT;
                    else if (nullInt) next_state = intPending ? CPX_INTR : CPX_RESP;
                    else if (nullDone) next_state = CPX_DONE;
                end
            CPX_SAVE: if (waiting && busErr) next_state = CPX_EXC;
                else if (waiting && busAck) begin
                    if (saveNotReady) next_state = intPending ? CPX_INTR : CPX_SAVE;
                    else if (saveLenBad) next_state = CPX_ABORT;
                    else next_state = CPX_DONE;
                end
            CPX_RWR: if (waiting && busErr) next_state = CPX_EXC;
                else if (waiting && busAck) next_state = restLenBad ? CPX_RRD : CPX_DONE;
            CPX_RRD: if (waiting && busErr) next_state = CPX_EXC;
                else if (waiting && busAck) next_state = CPX_ABORT;
            CPX_ABORT: if (waiting && (busAck || busErr)) next_state = CPX_EXC;
            CPX_INTR: if (excReturn) next_state = intFromSave ? CPX_SAVE : CPX_RESP;
            CPX_EXC: next_state = CPX_IDLE;
            CPX_DONE: next_state = CPX_IDLE;
            default: next_state = CPX_IDLE;
        endcase
    end

    // Exception vector and frame chosen at the cycle the cause is seen
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pendVec <= `CPX_VEC_INT;
            pendFrame <= `CPX_FRAME_PRE;
        end else if (state == CPX_IDLE && addrErr) begin
            pendVec <= `CPX_VEC_ADR;
            pendFrame <= `CPX_FRAME_PRE;
        end else if (waiting && busErr && state != CPX_ABORT) begin
            pendVec <= firstAccess ? `CPX_VEC_EMU : `CPX_VEC_BUS;
            pendFrame <= firstAccess ? `CPX_FRAME_PRE : `CPX_FRAME_MID;
        end else if (waiting && busAck && state == CPX_RESP && protErr) begin
            pendVec <= `CPX_VEC_PROT;
            pendFrame <= `CPX_FRAME_MID;
        end else if (waiting && busAck && (state == CPX_SAVE || state == CPX_RRD)) begin
            pendVec <= `CPX_VEC_FMT;
            pendFrame <= `CPX_FRAME_PRE;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= CPX_IDLE;
            op <= CPX_OP_GEN;
            firstAccess <= 1'b0;
            pending <= 1'b0;
            restoreWord <= 16'h0000;
            intFromSave <= 1'b0;
        end else begin
            state <= next_state;
            if (state == CPX_IDLE && start) begin
                op <= opKind;
                firstAccess <= 1'b1;
                restoreWord <= memFormatWord;
            end else if (waiting && (busAck || busErr)) begin
                firstAccess <= 1'b0;
            end
            if (stepReq) pending <= 1'b1;
            else if (busAck || busErr) pending <= 1'b0;
            if (next_state == CPX_INTR && state != CPX_INTR)
                intFromSave <= (state == CPX_SAVE);
        end
    end

    wire logic enter = next_state != state || (waiting && (busAck || busErr));
    wire logic issue = enter && !(next_state == CPX_INTR ||
        next_state == CPX_EXC || next_state == CPX_DONE || next_state == CPX_IDLE);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            readResponse <= 1'b0;
            readSave <= 1'b0;
            writeRestore <= 1'b0;
            readRestore <= 1'b0;
            writeAbort <= 1'b0;
            busWdata <= 16'h0000;
            excTake <= 1'b0;
            excVector <= `CPX_VEC_INT;
            excFrameWords <= `CPX_FRAME_PRE;
            intService <= 1'b0;
            busy <= 1'b0;
            instrDone <= 1'b0;
        end else begin
            readResponse <= issue && next_state == CPX_RESP;
            readSave <= issue && next_state == CPX_SAVE;
            writeRestore <= issue && next_state == CPX_RWR;
            readRestore <= issue && next_state == CPX_RRD;
            writeAbort <= issue && next_state == CPX_ABORT;
            busWdata <= (next_state == CPX_RWR) ? restoreSrc : 16'h0000;
            excTake <= state == CPX_EXC;
            if (state == CPX_EXC) begin
                excVector <= pendVec;
                excFrameWords <= pendFrame;
            end else if (next_state == CPX_INTR && state != CPX_INTR) begin
                excVector <= `CPX_VEC_INT;
                excFrameWords <= (state == CPX_SAVE) ?
                    `CPX_FRAME_PRE : `CPX_FRAME_MID;
            end
            intService <= next_state == CPX_INTR && state != CPX_INTR;
            busy <= next_state != CPX_IDLE;
            instrDone <= state == CPX_DONE;
        end
    end

    // binds the coprocessor; only the external rst clears this block.

    property p_midFrame;
        @(posedge mclk) disable iff (rst)
        (state == CPX_RESP && waiting && busAck && nullInt && intPending)
            |=> intService && excFrameWords == `CPX_FRAME_MID;
    endproperty
    a_midFrame: assert property (p_midFrame) else $error("mid frame");

    property p_noFrame;
        @(posedge mclk) disable iff (rst)
        (state == CPX_RESP && waiting && busAck && nullInt && !intPending)
            |=> !intService ##0 readResponse;
    endproperty
    a_noFrame: assert property (p_noFrame) else $error("no frame");

    property p_saveRetry;
        @(posedge mclk) disable iff (rst)
        (state == CPX_SAVE && waiting && busAck && saveNotReady && intPending)
            |=> intService && excFrameWords == `CPX_FRAME_PRE;
    endproperty
    a_saveRetry: assert property (p_saveRetry) else $error("save int");

    property p_saveAbort;
        @(posedge mclk) disable iff (rst)
        (state == CPX_SAVE && waiting && busAck && !saveNotReady && saveLenBad)
            |=> writeAbort;
    endproperty
    a_saveAbort: assert property (p_saveAbort) else $error("save abort");

    property p_fmtVec;
        @(posedge mclk) disable iff (rst)
        excTake && $past(state, 2) == CPX_ABORT && pendVec == `CPX_VEC_FMT
            |-> excVector == `CPX_VEC_FMT && excFrameWords == `CPX_FRAME_PRE;
    endproperty
    a_fmtVec: assert property (p_fmtVec) else $error("format vector");

    property p_absent;
        @(posedge mclk) disable iff (rst)
        (waiting && busErr && firstAccess && state != CPX_ABORT)
            |-> ##2 excTake && excVector == `CPX_VEC_EMU;
    endproperty
    a_absent: assert property (p_absent) else $error("absent copro");

    property p_busErr;
        @(posedge mclk) disable iff (rst)
        (waiting && busErr && !firstAccess && state != CPX_ABORT)
            |-> ##2 excTake && excVector == `CPX_VEC_BUS;
    endproperty
    a_busErr: assert property (p_busErr) else $error("bus error");

    property p_addr;
        @(posedge mclk) disable iff (rst)
        (state == CPX_IDLE && addrErr)
            |-> ##2 excTake && excVector == `CPX_VEC_ADR;
    endproperty
    a_addr: assert property (p_addr) else $error("address error");

    property p_prot;
        @(posedge mclk) disable iff (rst)
        (state == CPX_RESP && waiting && busAck && protErr) |=> writeAbort;
    endproperty
    a_prot: assert property (p_prot) else $error("protocol");

    property p_restSeq;
        @(posedge mclk) disable iff (rst)
        (state == CPX_RWR && waiting && busAck && restLenBad) |=> readRestore;
    endproperty
    a_restSeq: assert property (p_restSeq) else $error("restore seq");

    property p_caIntr;
        @(posedge mclk) disable iff (rst)
        (state == CPX_RESP && waiting && busAck && isNull && caFlag &&
            iaFlag && intPending) |=> intService && !readResponse;
    endproperty
    a_caIntr: assert property (p_caIntr) else $error("ca int");

    property p_traceIntr;
        @(posedge mclk) disable iff (rst)
        (state == CPX_RESP && waiting && busAck && isNull && !caFlag &&
            iaFlag && !pfFlag && tracePending && op == CPX_OP_GEN &&
            intPending) |=> intService;
    endproperty
    a_traceIntr: assert property (p_traceIntr) else $error("trace int");

    property p_traceHold;
        @(posedge mclk) disable iff (rst)
        (state == CPX_RESP && waiting && busAck && isNull && !caFlag &&
            !iaFlag && !pfFlag && tracePending && op == CPX_OP_GEN)
            |=> readResponse && !instrDone;
    endproperty
    a_traceHold: assert property (p_traceHold) else $error("trace hold");

    property p_resumeRead;
        @(posedge mclk) disable iff (rst)
        (state == CPX_INTR && excReturn && !intFromSave) |=> readResponse;
    endproperty
    a_resumeRead: assert property (p_resumeRead) else $error("resume");

    property p_saveResume;
        @(posedge mclk) disable iff (rst)
        (state == CPX_INTR && excReturn && intFromSave) |=> readSave;
    endproperty
    a_saveResume: assert property (p_saveResume) else $error("save redo");

    property p_lenOk;
        @(posedge mclk) disable iff (rst)
        (state == CPX_SAVE && waiting && busAck && !saveNotReady &&
            !saveLenBad) |=> !writeAbort ##1 instrDone;
    endproperty
    a_lenOk: assert property (p_lenOk) else $error("length ok");

    property p_emuFrame;
        @(posedge mclk) disable iff (rst)
        (excTake && excVector == `CPX_VEC_EMU)
            |-> excFrameWords == `CPX_FRAME_PRE;
    endproperty
    a_emuFrame: assert property (p_emuFrame) else $error("emu frame");
endmodule
`default_nettype wire

/* File: verif/cpx_coproc_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Coprocessor stand-in; answers each access after a random delay
module cpx_coproc_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic readResponse,
    input wire logic readSave,
    input wire logic writeRestore,
    input wire logic readRestore,
    input wire logic writeAbort,
    input wire logic [15:0] busWdata,
    output logic busAck,
    output logic busErr,
    output logic [15:0] busRdata,
    output logic [14:0] reqLog,
    output logic [15:0] lastWdata
);
    logic [16:0] script[$];
    logic [16:0] item;
    wire isWrite = writeRestore | writeAbort;
    wire anyReq = readResponse | readSave | readRestore | isWrite;
    wire [2:0] code = readSave ? 3'h2 : writeRestore ? 3'h3 :
        readRestore ? 3'h4 : writeAbort ? 3'h5 : 3'h1;
    task automatic push(input logic err, input logic [15:0] w);
        script.push_back({err, w});
    endtask
    initial begin
        busAck = 1'b0;
        busErr = 1'b0;
        busRdata = 16'h0;
        reqLog = 15'h0;
        lastWdata = 16'h0;
    end
    always begin
        @(posedge mclk);
        if (rst) begin
            script.delete();
            reqLog <= 15'h0;
        end else if (anyReq) begin
            reqLog <= {reqLog[11:0], code};
            if (writeRestore)
                lastWdata <= busWdata;
            item = 17'h0;
            if (!isWrite && script.size() > 0)
                item = script.pop_front();
            repeat ($urandom_range(3)) @(posedge mclk);
            busAck <= ~item[16];
            busErr <= item[16];
            busRdata <= item[15:0];
            @(posedge mclk);
            busAck <= 1'b0;
            busErr <= 1'b0;
            busRdata <= ~item[15:0]; // Released bus shows no stale value
        end
    end
endmodule
`default_nettype wire

/* File: verif/tb_coprocessor_exception_handling.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_coprocessor_exception_handling;
    import cpx_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, start = 1'b0, tracePending = 1'b0;
    logic intPending = 1'b0, prefetchReq = 1'b0, excReturn = 1'b0;
    logic [1:0] opKind = 2'h0;
    logic [15:0] memFormatWord = 16'h0;
    logic [31:0] prefetchAddr = 32'h0;
    logic [31:0] addr;
    wire busAck, busErr, rdRsp, rdSav, wrRst, rdRst, wrAbt;
    wire [15:0] busRdata, busWdata, lastWdata;
    wire excTake, intService, busy, instrDone;
    wire [7:0] excVector;
    wire [3:0] excFrameWords;
    wire [14:0] reqLog;
    logic [13:0] expq[$];
    logic [13:0] got, want;
    logic [5:0] badFc[16] = '{6'h00, 6'h3f, 6'h0b, 6'h18, 6'h19, 6'h1a,
        6'h1b, 6'h1f, 6'h28, 6'h29, 6'h2a, 6'h2b, 6'h38, 6'h39, 6'h3a, 6'h3b};
    int bad_count = 0, num_checks = 0;
    cpx_exc_ctrl i_cpx_exc_ctrl (.mclk(mclk), .rst(rst), .start(start),
        .opKind(opKind), .tracePending(tracePending),
        .intPending(intPending), .memFormatWord(memFormatWord),
        .prefetchReq(prefetchReq), .prefetchAddr(prefetchAddr),
        .busAck(busAck), .busErr(busErr), .busRdata(busRdata),
        .excReturn(excReturn), .readResponse(rdRsp), .readSave(rdSav),
        .writeRestore(wrRst), .readRestore(rdRst), .writeAbort(wrAbt),
        .busWdata(busWdata), .excTake(excTake), .excVector(excVector),
        .excFrameWords(excFrameWords), .intService(intService),
        .busy(busy), .instrDone(instrDone));
    cpx_coproc_model i_cpx_coproc_model (.mclk(mclk), .rst(rst),
        .readResponse(rdRsp), .readSave(rdSav), .writeRestore(wrRst),
        .readRestore(rdRst), .writeAbort(wrAbt), .busWdata(busWdata),
        .busAck(busAck), .busErr(busErr), .busRdata(busRdata),
        .reqLog(reqLog), .lastWdata(lastWdata));
    always #5 mclk = ~mclk;
    always @(posedge mclk) excReturn <= intService;
    task automatic report_and_stop;
        if (bad_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // Result kind: 1 done, 2 exception, 3 interrupt, 0 any kind and any frame
    always @(posedge mclk) begin
        if (instrDone === 1'b1 || excTake === 1'b1 || intService === 1'b1) begin
            got = {instrDone ? 2'd1 : intService ? 2'd3 : 2'd2, excVector,
                excFrameWords};
            want = (expq.size() > 0) ? expq.pop_front() : 14'h3fff;
            if (want[13:12] < 2'd2)
                got[3:0] = want[3:0];
            if (want[13:12] == 2'd1)
                got[11:4] = want[11:4];
            if (want[13:12] == 2'd0)
                got[13:12] = 2'd0;
            chk({2'h0, got}, {2'h0, want});
        end
    end
    task automatic run(input cpx_op_e op, input logic [15:0] mem,
        input logic tr, input logic ip, input logic [13:0] e1,
        input logic [13:0] e2);
        int n;
        if (e1 != 14'h0)
            expq.push_back(e1);
        if (e2 != 14'h0)
            expq.push_back(e2);
        @(posedge mclk);
        start <= 1'b1;
        opKind <= op;
        memFormatWord <= mem;
        tracePending <= tr;
        intPending <= ip;
        @(posedge mclk);
        start <= 1'b0;
        n = 0;
        @(posedge mclk);
        while (busy !== 1'b0 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        chk(16'(n == 300), 16'h0);
        intPending <= 1'b0;
        tracePending <= 1'b0;
    endtask
    initial begin
        #200000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'ha9f3));
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        // Model clears its script while it still sees reset
        @(posedge mclk);
        i_cpx_coproc_model.push(1'b0, 16'h0802);
        run(CPX_OP_GEN, 16'h0, 1'b0, 1'b0, 14'h1000, 14'h0);
        i_cpx_coproc_model.push(1'b0, 16'h8900);
        i_cpx_coproc_model.push(1'b0, 16'h0802);
        run(CPX_OP_GEN, 16'h0, 1'b0, 1'b1, 14'h300a, 14'h1000);
        i_cpx_coproc_model.push(1'b0, 16'h8900);
        i_cpx_coproc_model.push(1'b0, 16'h0802);
        run(CPX_OP_COND, 16'h0, 1'b0, 1'b0, 14'h1000, 14'h0);
        i_cpx_coproc_model.push(1'b0, 16'h0900);
        i_cpx_coproc_model.push(1'b0, 16'h0802);
        run(CPX_OP_GEN, 16'h0, 1'b1, 1'b1, 14'h300a, 14'h1000);
        i_cpx_coproc_model.push(1'b0, 16'h0800);
        i_cpx_coproc_model.push(1'b0, 16'h0802);
        run(CPX_OP_GEN, 16'h0, 1'b1, 1'b1, 14'h1000, 14'h0);
        chk(16'(reqLog[5:0]), 16'h0009);
        i_cpx_coproc_model.push(1'b0, 16'h0100);
        i_cpx_coproc_model.push(1'b0, 16'h0005);
        run(CPX_OP_SAVE, 16'h0, 1'b0, 1'b1, 14'h3004, 14'h20e4);
        chk(16'(reqLog[8:0]), 16'h0095);
        run(CPX_OP_RESTORE, 16'h0006, 1'b0, 1'b0, 14'h20e4, 14'h0);
        chk(16'(reqLog[8:0]), 16'h00e5);
        chk(lastWdata, 16'h0006);
        i_cpx_coproc_model.push(1'b0, 16'h0104);
        run(CPX_OP_SAVE, 16'h0, 1'b0, 1'b0, 14'h1000, 14'h0);
        run(CPX_OP_RESTORE, 16'h0008, 1'b0, 1'b0, 14'h1000, 14'h0);
        chk(lastWdata, 16'h0008);
        i_cpx_coproc_model.push(1'b1, 16'h0);
        run(CPX_OP_GEN, 16'h0, 1'b0, 1'b0, 14'h20b4, 14'h0);
        i_cpx_coproc_model.push(1'b0, 16'h8800);
        i_cpx_coproc_model.push(1'b1, 16'h0);
        run(CPX_OP_GEN, 16'h0, 1'b0, 1'b0, 14'h202a, 14'h0);
        foreach (badFc[i]) begin
            i_cpx_coproc_model.push(1'b0, {2'b00, badFc[i], 8'h00});
            run(CPX_OP_GEN, 16'h0, 1'b0, 1'b0, 14'h20da, 14'h0);
            chk(16'(reqLog[5:0]), 16'h000d);
        end
        for (int i = 0; i < 4; i++) begin
            addr = $urandom() | 32'(i == 0);
            if (addr[0])
                expq.push_back(14'h0030);
            @(posedge mclk);
            prefetchReq <= 1'b1;
            prefetchAddr <= addr;
            @(posedge mclk);
            prefetchReq <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        chk(16'(expq.size()), 16'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
